// ### verilog/torque_limit_selector.sv
// Torque / force limit selector with analog limit path and reference clamp
//
// What this block does
// [RL1] Rotary forward internal torque limit, 0..800 %, reset 800, live on write.
// [RL2] Rotary reverse internal torque limit, 0..800 %, reset 800, live on write.
// [RL3] Forward external limit, 0..800 %, reset 100, shared rotary/linear, live.
// [RL4] Reverse external limit, 0..800 %, reset 100, shared rotary/linear, live.
// [RL5] Linear forward internal force limit, 0..800 %, reset 30, replaces rotary one.
// [RL6] Linear reverse internal force limit, 0..800 %, reset 30, replaces rotary one.
// [RL7] In analog mode each direction is the smaller of analog limit and internal limit.
// [RL8] The analog limit uses the voltage magnitude and applies to both directions.
// [RL9] Analog mode is chosen by source select value 1, sampled only at restart.
// [RL10] The voltage is scaled by a 10..100 gain in 0.1 V, reset 30 (rated at 3.0 V).
// [RL11] The analog limit is low-pass filtered, time constant 0..65535 x 0.01 ms, reset 0.
// [RL12] Forward request active outside analog mode limits forward to min of internal and external setting.
// [RL13] Reverse request active outside analog mode limits reverse to min of internal and external setting.
// [RL14] Any effective limit above the motor maximum is clamped to that maximum.
// [RL15] The signed torque reference is saturated to +forward and -reverse limits.
`timescale 1ns/100ps

module torque_limit_selector
    import torque_limit_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    input  wire setting_write_t     setting_wr,
    input  wire logic               linear_motor,
    input  wire logic [3:0]         limit_source_select,
    input  wire logic               fwd_ext_limit_request_n,
    input  wire logic               rev_ext_limit_request_n,
    input  wire logic signed [15:0] analog_limit_voltage,
    input  wire logic [9:0]         motor_max_limit,
    input  wire logic signed [15:0] torque_ref,
    output      limit_out_t         limits,
    output      logic signed [15:0] torque_out
);

    localparam selector_state_t STATE_RESET = '{
        set: '{
            fwd_internal_torque_limit: INT_TORQUE_RST,
            rev_internal_torque_limit: INT_TORQUE_RST,
            fwd_external_limit:        EXT_LIMIT_RST,
            rev_external_limit:        EXT_LIMIT_RST,
            fwd_internal_force_limit:  INT_FORCE_RST,
            rev_internal_force_limit:  INT_FORCE_RST,
            analog_limit_input_gain:   GAIN_RST,
            analog_limit_filter_tc:    FILTER_TC_RST
        },
        req_meta:  2'h3,
        req_sync:  2'h3,
        div_state: DIV_IDLE,
        default:   '0
    };

    selector_state_t s;
    selector_state_t next_s;
    logic            fwd_on;
    logic            rev_on;
    logic            tick;
    logic [9:0]      fwd_base;
    logic [9:0]      rev_base;
    logic [9:0]      fwd_eff;
    logic [9:0]      rev_eff;
    logic [4:0]      filt_shift;
    logic [24:0]     filt_diff;
    logic [15:0]     volt_mag;
    logic [7:0]      rem_shift;
    logic            quo_bit;

    function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
        min10 = (a < b) ? a : b;
    endfunction : min10

    // Shift k with 2**k >= tc+1; a power-of-two step keeps the filter divider-free
    function automatic logic [4:0] tc_shift(input logic [15:0] tc);
        logic [16:0] span;
        span = {1'b0, tc} + 17'h0_0001;
        tc_shift = 5'h00;
        for (int i = 0; i < 17; i++) begin
            if ((17'h0_0001 << i) < span) begin
                tc_shift = 5'(i + 1);
            end
        end
    endfunction : tc_shift

    assign limits     = s.limits;
    assign torque_out = s.torque_out;
    assign fwd_on     = ~s.req_sync[1];
    assign rev_on     = ~s.req_sync[0];
    assign tick       = (s.tick_cnt == 9'(FILTER_STEP_CYCLES - 1));

    // ========================================================================
    // Next state
    always_comb begin
        next_s = s;
        filt_shift = tc_shift(s.set.analog_limit_filter_tc);
        filt_diff  = 25'($signed({analog_limit_voltage, 8'h00}) - s.volt_acc);
        volt_mag   = s.volt_acc[23] ? 16'(-s.volt_acc[23:8]) : s.volt_acc[23:8];
        rem_shift  = {s.div_rem, s.div_quo[15]};
        quo_bit    = (rem_shift >= {1'b0, s.set.analog_limit_input_gain});

        // Request pins are asynchronous to sys_clk
        next_s.req_meta = {fwd_ext_limit_request_n, rev_ext_limit_request_n};
        next_s.req_sync = s.req_meta;

        // [RL9] mode caught once after restart
        if (!s.started) begin
            next_s.started     = 1'b1;
            next_s.analog_mode = (limit_source_select == ANALOG_SOURCE_SEL);
        end

        // Out-of-range writes are dropped and the old value kept
        if (setting_wr.valid) begin
            unique case (setting_wr.id)
                // [RL1] forward torque setting
                SET_FWD_INT_TORQUE: begin
                    if (setting_wr.data <= 16'(LIMIT_SETTING_MAX)) begin
                        next_s.set.fwd_internal_torque_limit = setting_wr.data[9:0];
                    end
                end
                // [RL2] reverse torque setting
                SET_REV_INT_TORQUE: begin
                    if (setting_wr.data <= 16'(LIMIT_SETTING_MAX)) begin
                        next_s.set.rev_internal_torque_limit = setting_wr.data[9:0];
                    end
                end
                // [RL3] forward external setting
                SET_FWD_EXTERNAL: begin
                    if (setting_wr.data <= 16'(LIMIT_SETTING_MAX)) begin
                        next_s.set.fwd_external_limit = setting_wr.data[9:0];
                    end
                end
                // [RL4] reverse external setting
                SET_REV_EXTERNAL: begin
                    if (setting_wr.data <= 16'(LIMIT_SETTING_MAX)) begin
                        next_s.set.rev_external_limit = setting_wr.data[9:0];
                    end
                end
                // [RL5] forward force setting
                SET_FWD_INT_FORCE: begin
                    if (setting_wr.data <= 16'(LIMIT_SETTING_MAX)) begin
                        next_s.set.fwd_internal_force_limit = setting_wr.data[9:0];
                    end
                end
                // [RL6] reverse force setting
                SET_REV_INT_FORCE: begin
                    if (setting_wr.data <= 16'(LIMIT_SETTING_MAX)) begin
                        next_s.set.rev_internal_force_limit = setting_wr.data[9:0];
                    end
                end
                // [RL10] gain setting
                SET_INPUT_GAIN: begin
                    if (setting_wr.data >= 16'(GAIN_MIN) && setting_wr.data <= 16'(GAIN_MAX)) begin
                        next_s.set.analog_limit_input_gain = setting_wr.data[6:0];
                    end
                end
                // [RL11] filter setting
                SET_FILTER_TC: begin
                    next_s.set.analog_limit_filter_tc = setting_wr.data;
                end
            endcase
        end

        // ====================================================================
        // Analog path: filter step, then magnitude divided by gain
        next_s.tick_cnt = tick ? 9'h000 : 9'(s.tick_cnt + 9'h001);
        if (tick) begin
            // [RL11] first-order low-pass
            next_s.volt_acc = 24'($signed(s.volt_acc) + ($signed(filt_diff) >>> filt_shift));
        end
        unique case (s.div_state)
            DIV_IDLE: begin
                if (tick) begin
                    // [RL8] magnitude only
                    next_s.div_quo   = volt_mag;
                    next_s.div_rem   = 7'h00;
                    next_s.div_cnt   = 4'h0;
                    next_s.div_state = DIV_RUN;
                end
            end
            DIV_RUN: begin
                // [RL10] mV / (gain x 0.1 V) gives percent of rated
                next_s.div_rem = quo_bit ? 7'(rem_shift - {1'b0, s.set.analog_limit_input_gain})
                                         : rem_shift[6:0];
                next_s.div_quo = {s.div_quo[14:0], quo_bit};
                next_s.div_cnt = 4'(s.div_cnt + 4'h1);
                if (s.div_cnt == 4'(DIV_STEPS - 1)) begin
                    next_s.div_state  = DIV_IDLE;
                    next_s.analog_pct = ({s.div_quo[14:0], quo_bit} > 16'(LIMIT_SETTING_MAX))
                                        ? LIMIT_SETTING_MAX : s.div_quo[8:0] == 9'h000 && !quo_bit
                                        ? 10'h000 : 10'({s.div_quo[14:0], quo_bit});
                end
            end
        endcase

        // ====================================================================
        // Effective limits
        // [RL5] force settings replace torque settings on linear motors
        fwd_base = linear_motor ? s.set.fwd_internal_force_limit : s.set.fwd_internal_torque_limit;
        rev_base = linear_motor ? s.set.rev_internal_force_limit : s.set.rev_internal_torque_limit;
        fwd_eff  = fwd_base;
        rev_eff  = rev_base;
        if (s.analog_mode) begin
            // [RL7] analog limit against internal limit
            fwd_eff = min10(fwd_base, s.analog_pct);
            rev_eff = min10(rev_base, s.analog_pct);
        end else begin
            // [RL12] forward external request
            if (fwd_on) begin
                fwd_eff = min10(fwd_base, s.set.fwd_external_limit);
            end
            // [RL13] reverse external request
            if (rev_on) begin
                rev_eff = min10(rev_base, s.set.rev_external_limit);
            end
        end
        // [RL14] motor maximum clamp
        fwd_eff = min10(fwd_eff, motor_max_limit);
        rev_eff = min10(rev_eff, motor_max_limit);
        next_s.limits.fwd         = fwd_eff;
        next_s.limits.rev         = rev_eff;
        next_s.limits.analog_mode = s.analog_mode;

        // [RL15] reference saturation
        if (torque_ref > $signed({6'h00, fwd_eff})) begin
            next_s.torque_out = $signed({6'h00, fwd_eff});
        end else if (torque_ref < -$signed({6'h00, rev_eff})) begin
            next_s.torque_out = -$signed({6'h00, rev_eff});
        end else begin
            next_s.torque_out = torque_ref;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_fwd_int_limit: assert property ( // [RL1]
        !linear_motor && !s.analog_mode |=> limits.fwd <= $past(s.set.fwd_internal_torque_limit))
        else $error("forward limit above torque setting");
    chk_rev_int_limit: assert property ( // [RL2]
        !linear_motor && !s.analog_mode |=> limits.rev <= $past(s.set.rev_internal_torque_limit))
        else $error("reverse limit above torque setting");
    chk_fwd_ext_limit: assert property ( // [RL12]
        fwd_on && !s.analog_mode |=> limits.fwd <= $past(s.set.fwd_external_limit))
        else $error("forward limit above external setting");
    chk_rev_ext_limit: assert property ( // [RL13]
        rev_on && !s.analog_mode |=> limits.rev <= $past(s.set.rev_external_limit))
        else $error("reverse limit above external setting");
    chk_fwd_sync_delay: assert property ( // [RL12]
        $fell(fwd_ext_limit_request_n) |-> ##2 fwd_on)
        else $error("forward request not seen two edges later");
    chk_rev_sync_delay: assert property ( // [RL13]
        $fell(rev_ext_limit_request_n) |-> ##2 rev_on)
        else $error("reverse request not seen two edges later");
    chk_force_limits: assert property ( // [RL6]
        linear_motor |=> limits.fwd <= $past(s.set.fwd_internal_force_limit)
                         && limits.rev <= $past(s.set.rev_internal_force_limit))
        else $error("limit above force setting");
    chk_analog_both_dirs: assert property ( // [RL7]
        s.analog_mode |=> limits.fwd <= $past(s.analog_pct) && limits.rev <= $past(s.analog_pct))
        else $error("limit above analog limit");
    chk_max_clamp: assert property ( // [RL14]
        1'b1 |=> limits.fwd <= $past(motor_max_limit) && limits.rev <= $past(motor_max_limit))
        else $error("limit above motor maximum");
    chk_torque_sat: assert property ( // [RL15]
        s.started |-> torque_out <= $signed({6'h00, limits.fwd}) && torque_out >= -$signed({6'h00, limits.rev}))
        else $error("torque output outside limits");
    chk_mode_frozen: assert property ( // [RL9]
        s.started |=> $stable(s.analog_mode))
        else $error("analog mode changed without restart");
    chk_mode_latch: assert property ( // [RL9]
        !s.started |=> s.analog_mode == $past(limit_source_select == ANALOG_SOURCE_SEL))
        else $error("analog mode not taken at restart");
    chk_gain_range: assert property ( // [RL10]
        s.set.analog_limit_input_gain >= GAIN_MIN && s.set.analog_limit_input_gain <= GAIN_MAX)
        else $error("gain outside range");
    // Step counter stands in for a long repetition; it only climbs while running
    chk_divide_length: assert property ( // [RL10]
        $rose(s.div_state == DIV_RUN) |-> s.div_cnt == 4'h0
            ##15 s.div_state == DIV_RUN && s.div_cnt == 4'hf ##1 s.div_state == DIV_IDLE)
        else $error("divide not sixteen cycles");
    chk_filter_bypass: assert property ( // [RL11]
        tick && s.set.analog_limit_filter_tc == 16'h0000 |=> s.volt_acc == $signed({$past(analog_limit_voltage), 8'h00}))
        else $error("zero time constant did not pass input");

    cov_fwd_external: cover property (fwd_on && !s.analog_mode ##1 limits.fwd < limits.rev);
    cov_analog_done: cover property (s.analog_mode && s.div_state == DIV_RUN ##16 s.div_state == DIV_IDLE);
    cov_torque_clamped: cover property (torque_ref > $signed({6'h00, limits.fwd}) ##1 torque_out > 16'sh0000);
    cov_rev_external: cover property (rev_on && !s.analog_mode ##1 limits.rev < 10'h320);
    cov_linear_force: cover property (linear_motor && !s.analog_mode ##1 limits.fwd != limits.rev);

endmodule : torque_limit_selector

// ### verilog/torque_limit_pkg.sv
// Constants, carrier types and state layout for the torque limit selector
package torque_limit_pkg;

    // ========================================================================
    // Widths
    localparam int LIMIT_W = 10;
    localparam int VOLT_W  = 16;

    // ========================================================================
    // Setting ranges and reset values (percent of rated, gain in 0.1 V)
    localparam logic [9:0]  LIMIT_SETTING_MAX = 10'h320;
    localparam logic [9:0]  INT_TORQUE_RST    = 10'h320;
    localparam logic [9:0]  EXT_LIMIT_RST     = 10'h064;
    localparam logic [9:0]  INT_FORCE_RST     = 10'h01e;
    localparam logic [6:0]  GAIN_MIN          = 7'h0a;
    localparam logic [6:0]  GAIN_MAX          = 7'h64;
    localparam logic [6:0]  GAIN_RST          = 7'h1e;
    localparam logic [15:0] FILTER_TC_RST     = 16'h0000;
    localparam logic [3:0]  ANALOG_SOURCE_SEL = 4'h1;

    // ========================================================================
    // Timing: one filter step per 0.01 ms
    localparam int CLK_PERIOD_NS      = 20;
    localparam int FILTER_STEP_NS     = 10000;
    localparam int FILTER_STEP_CYCLES = FILTER_STEP_NS / CLK_PERIOD_NS;
    localparam int DIV_STEPS          = 16;

    // ========================================================================
    // Carriers
    typedef enum logic [2:0] {
        SET_FWD_INT_TORQUE,
        SET_REV_INT_TORQUE,
        SET_FWD_EXTERNAL,
        SET_REV_EXTERNAL,
        SET_FWD_INT_FORCE,
        SET_REV_INT_FORCE,
        SET_INPUT_GAIN,
        SET_FILTER_TC
    } setting_id_t;

    typedef struct packed {
        logic        valid;
        setting_id_t id;
        logic [15:0] data;
    } setting_write_t;

    typedef struct packed {
        logic [9:0]  fwd_internal_torque_limit;
        logic [9:0]  rev_internal_torque_limit;
        logic [9:0]  fwd_external_limit;
        logic [9:0]  rev_external_limit;
        logic [9:0]  fwd_internal_force_limit;
        logic [9:0]  rev_internal_force_limit;
        logic [6:0]  analog_limit_input_gain;
        logic [15:0] analog_limit_filter_tc;
    } limit_settings_t;

    typedef struct packed {
        logic [9:0] fwd;
        logic [9:0] rev;
        logic       analog_mode;
    } limit_out_t;

    typedef enum logic {
        DIV_IDLE,
        DIV_RUN
    } div_state_t;

    typedef struct packed {
        limit_settings_t    set;
        logic               started;
        logic               analog_mode;
        logic [1:0]         req_meta;
        logic [1:0]         req_sync;
        logic [8:0]         tick_cnt;
        logic signed [23:0] volt_acc;
        div_state_t         div_state;
        logic [3:0]         div_cnt;
        logic [15:0]        div_quo;
        logic [6:0]         div_rem;
        logic [9:0]         analog_pct;
        limit_out_t         limits;
        logic signed [15:0] torque_out;
    } selector_state_t;

endpackage : torque_limit_pkg

// ### sim/host_model.sv
// Host controller model driving the limit request contacts and the analog voltage
`timescale 1ns/100ps

module host_model (
    input  wire logic               sys_clk,
    input  wire logic               fwd_cmd,
    input  wire logic               rev_cmd,
    input  wire logic signed [15:0] volt_cmd,
    input  wire logic [3:0]         lag,
    output      logic               fwd_ext_limit_request_n,
    output      logic               rev_ext_limit_request_n,
    output      logic signed [15:0] analog_limit_voltage
);
    // ========================================================================
    // Contact and voltage outputs
    initial begin
        fwd_ext_limit_request_n = 1'b1;
        rev_ext_limit_request_n = 1'b1;
        analog_limit_voltage    = 16'sh0000;
    end

    // Contacts settle lag+1 cycles late and off the edge, as a slow relay would
    always begin
        @(fwd_cmd or rev_cmd or volt_cmd);
        repeat (lag + 1) @(posedge sys_clk);
        #3;
        fwd_ext_limit_request_n = !fwd_cmd;
        rev_ext_limit_request_n = !rev_cmd;
        analog_limit_voltage    = volt_cmd;
    end
endmodule : host_model

// ### sim/test_torque_limit_selector.sv
// Self-checking bench for the torque limit selector
`timescale 1ns/100ps

module test_torque_limit_selector
    import torque_limit_pkg::*;
;
    typedef struct {
        int          sel;
        logic [15:0] val;
    } note_t;

    logic               sys_clk;
    logic               rstn;
    setting_write_t     setting_wr;
    logic               linear_motor;
    logic [3:0]         limit_source_select;
    logic [9:0]         motor_max_limit;
    logic signed [15:0] torque_ref;
    logic               fwd_cmd;
    logic               rev_cmd;
    logic signed [15:0] volt_cmd;
    logic [3:0]         lag;
    wire                fwd_n;
    wire                rev_n;
    wire signed [15:0]  volt;
    limit_out_t         limits;
    logic signed [15:0] torque_out;
    note_t              notes[$];
    event               probe_ev;
    int                 fail_count   = 0;
    int                 total_checks = 0;
    int                 seed         = 55;
    int                 cycles       = 0;

    torque_limit_selector uut (
        .sys_clk                 (sys_clk),
        .rstn                    (rstn),
        .setting_wr              (setting_wr),
        .linear_motor            (linear_motor),
        .limit_source_select     (limit_source_select),
        .fwd_ext_limit_request_n (fwd_n),
        .rev_ext_limit_request_n (rev_n),
        .analog_limit_voltage    (volt),
        .motor_max_limit         (motor_max_limit),
        .torque_ref              (torque_ref),
        .limits                  (limits),
        .torque_out              (torque_out)
    );

    host_model host (
        .sys_clk                 (sys_clk),
        .fwd_cmd                 (fwd_cmd),
        .rev_cmd                 (rev_cmd),
        .volt_cmd                (volt_cmd),
        .lag                     (lag),
        .fwd_ext_limit_request_n (fwd_n),
        .rev_ext_limit_request_n (rev_n),
        .analog_limit_voltage    (volt)
    );

    // ========================================================================
    // Clock, timeout and verdict
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    // ========================================================================
    // Notes and the output watcher
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic note(input int sel, input logic [15:0] val);
        notes.push_back('{sel, val});
        -> probe_ev;
    endtask : note

    task automatic look(input logic [15:0] f, input logic [15:0] r);
        note(0, f);
        note(1, r);
    endtask : look

    initial begin : watcher
        note_t n;
        forever begin
            @(probe_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                case (n.sel)
                    0: check({6'h00, limits.fwd}, n.val);
                    1: check({6'h00, limits.rev}, n.val);
                    2: check(torque_out, n.val);
                    3: check({15'h0000, limits.analog_mode}, n.val);
                    4: check({15'h0000, limits.fwd < n.val[9:0]}, 16'h0001);
                    default: check({15'h0000, limits.rev < n.val[9:0]}, 16'h0001);
                endcase
            end
        end
    end

    // ========================================================================
    // Drivers
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic write_set(input setting_id_t id, input logic [15:0] d);
        setting_wr = '{1'b1, id, d};
        tick(1);
        setting_wr.valid = 1'b0;
        tick(3);
    endtask : write_set

    task automatic pins(input logic f, input logic r, input logic signed [15:0] v, input int n);
        fwd_cmd  = f;
        rev_cmd  = r;
        volt_cmd = v;
        tick(n);
    endtask : pins

    task automatic do_reset(input logic [3:0] sel);
        rstn                = 1'b0;
        limit_source_select = sel;
        tick(10);
        rstn = 1'b1;
        tick(3);
    endtask : do_reset

    initial begin : main
        int r;
        int e;
        rstn = 1'b0;
        setting_wr = '0;
        linear_motor = 1'b0;
        limit_source_select = 4'h0;
        motor_max_limit = 10'h320;
        torque_ref = 16'sh0000;
        fwd_cmd = 1'b0;
        rev_cmd = 1'b0;
        volt_cmd = 16'sh0000;
        lag = 4'h0;
        #2;
        do_reset(4'h0);
        look(16'h0320, 16'h0320);
        note(3, 16'h0000);
        // Select moves mid-run; mode must hold until the next restart
        limit_source_select = 4'h1;
        linear_motor = 1'b1;
        tick(2);
        look(16'h001e, 16'h001e);
        linear_motor = 1'b0;
        pins(1'b1, 1'b0, 16'sh0000, 6);
        look(16'h0064, 16'h0320);
        pins(1'b1, 1'b1, 16'sh0000, 6);
        look(16'h0064, 16'h0064);
        write_set(SET_FWD_EXTERNAL, 16'h0028);
        write_set(SET_REV_EXTERNAL, 16'h003c);
        look(16'h0028, 16'h003c);
        write_set(SET_FWD_INT_TORQUE, 16'h0014);
        // Out of range, must leave the old value in place
        write_set(SET_REV_INT_TORQUE, 16'h0321);
        look(16'h0014, 16'h003c);
        lag = 4'h3;
        pins(1'b0, 1'b0, 16'sh0000, 10);
        look(16'h0014, 16'h0320);
        write_set(SET_FWD_INT_FORCE, 16'h02bc);
        write_set(SET_REV_INT_FORCE, 16'h0005);
        linear_motor = 1'b1;
        tick(2);
        look(16'h02bc, 16'h0005);
        linear_motor = 1'b0;
        motor_max_limit = 10'h12c;
        tick(2);
        look(16'h0014, 16'h012c);
        note(3, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed) % 1000;
            torque_ref = r[15:0];
            tick(2);
            e = (r > 20) ? 20 : ((r < -300) ? -300 : r);
            note(2, e[15:0]);
        end
        torque_ref = 16'sh0000;
        lag = 4'h0;
        motor_max_limit = 10'h320;
        // Analog source only takes hold across a restart
        do_reset(4'h1);
        note(3, 16'h0001);
        limit_source_select = 4'h0;
        pins(1'b0, 1'b0, 16'sh05dc, 1200);
        look(16'h0032, 16'h0032);
        pins(1'b0, 1'b0, -16'sh0960, 1200);
        look(16'h0050, 16'h0050);
        write_set(SET_INPUT_GAIN, 16'h000f);
        write_set(SET_INPUT_GAIN, 16'h0009);
        pins(1'b1, 1'b1, -16'sh0960, 1200);
        look(16'h00a0, 16'h00a0);
        write_set(SET_FILTER_TC, 16'h03e8);
        pins(1'b1, 1'b1, 16'sh0bb8, 1200);
        note(4, 16'h00c8);
        note(5, 16'h00c8);
        write_set(SET_FWD_INT_TORQUE, 16'h0064);
        note(0, 16'h0064);
        note(5, 16'h00c8);
        note(3, 16'h0001);
        tick(1);
        summarize();
    end
endmodule : test_torque_limit_selector
